// ### hw/codec_frame_slot_config.sv
// Frame and time-slot configuration of a serial codec port.
// Assumes a classic Wishbone master and an external serial clock that is
// sampled by clk; the audio data path lives elsewhere.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module codec_frame_slot_config
    import codec_frame_slot_pkg::*;
#(
    parameter int NUM_SLOTS = 13
) (
    input wire logic clk, // 200 MHz system clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [17:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    output logic irq, // Level interrupt
    input wire logic codecSerialClock, // Serial clock from codec
    input wire logic priDataIn, // Serial data from primary codec
    input wire logic secDataIn, // Serial data from secondary codec
    output logic frameSync, // Frame sync, high during slot 0 in AC97 and mode 5, low while the port is off
    output logic txData, // Outgoing slot-0 tag stream
    output logic [3:0] slotIndex, // Current time slot
    output logic [5:0] bitIndex, // Bit within current slot
    output logic audioDataEn // Mode 5 audio data bit window
);
    // ==========================================================
    // Helpers
    function automatic logic [5:0] codeToCount(input logic [2:0] code);
        case (code)
            3'h0: codeToCount = 6'h08;
            3'h1: codeToCount = 6'h10;
            3'h2: codeToCount = 6'h12;
            3'h3: codeToCount = 6'h14;
            3'h4: codeToCount = 6'h18;
            default: codeToCount = 6'h20;
        endcase
    endfunction

    // ==========================================================
    // Reset release and input synchronisers
    logic [1:0] rstPipe_q;
    logic rstSync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_q[1];

    logic [2:0] sclkPipe_q;
    logic [1:0] priPipe_q, secPipe_q;
    logic sclkRise, sclkFall;
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sclkPipe_q <= 3'h0;
            priPipe_q <= 2'h0;
            secPipe_q <= 2'h0;
        end else begin
            sclkPipe_q <= {sclkPipe_q[1:0], codecSerialClock};
            priPipe_q <= {priPipe_q[0], priDataIn};
            secPipe_q <= {secPipe_q[0], secDataIn};
        end
    end
    assign sclkRise = sclkPipe_q[1] & ~sclkPipe_q[2];
    assign sclkFall = ~sclkPipe_q[1] & sclkPipe_q[2];

    // ==========================================================
    // Register file and Wishbone slave
    logic [1:0] mode_q, mode_d;
    logic [7:0] fmt_q, fmt_d, high_q, high_d, low_q, low_d;
    logic [2:0] status_q, status_d, mask_q, mask_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic priRdy_q, priRdy_d, secRdy_q, secRdy_d;
    logic irq_q, irq_d;
    logic [2:0] events;
    logic req, wrLane0;
    logic [15:0] idx;
    logic isAc97, isMode5;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign idx = wb_adr_i[17:2];
    assign wrLane0 = req & wb_we_i & wb_sel_i[0];
    assign isAc97 = (mode_q == MODE_AC97);
    assign isMode5 = (mode_q == MODE_I2S5);

    always_comb begin
        mode_d = mode_q;
        fmt_d = fmt_q;
        high_d = high_q;
        low_d = low_q;
        mask_d = mask_q;
        status_d = status_q;
        rdat_d = rdat_q;
        ack_d = req;
        if (wrLane0) begin
            case (idx)
                IDX_MODE: mode_d = wb_dat_i[1:0];
                IDX_IRQ_STATUS: status_d = status_q & ~wb_dat_i[2:0];
                IDX_IRQ_MASK: mask_d = wb_dat_i[2:0];
                IDX_RX_SLOT_FORMAT: fmt_d = {2'h0, wb_dat_i[5:0]};
                IDX_SLOT_FLAGS_HIGH: high_d = {wb_dat_i[7], 2'h0,
                                                wb_dat_i[4:0]};
                IDX_SLOT_FLAGS_LOW: low_d = {wb_dat_i[7:3], 3'h0};
                default: ;
            endcase
        end
        // Hardware events win over a simultaneous clear
        status_d = status_d | events;
        if (req && !wb_we_i) begin
            case (idx)
                IDX_MODE: rdat_d = {30'h0, mode_q};
                IDX_IRQ_STATUS: rdat_d = {29'h0, status_q};
                IDX_IRQ_MASK: rdat_d = {29'h0, mask_q};
                IDX_RX_SLOT_FORMAT: rdat_d = {24'h0, fmt_q};
                IDX_SLOT_FLAGS_HIGH: rdat_d = {24'h0, high_q[7], priRdy_q,
                                               secRdy_q, high_q[4:0]};
                IDX_SLOT_FLAGS_LOW: rdat_d = {24'h0, low_q};
                default: rdat_d = 32'h0;
            endcase
        end
        irq_d = |(status_q & mask_q);
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            mode_q <= MODE_RESET;
            fmt_q <= RX_SLOT_FORMAT_RESET;
            high_q <= SLOT_FLAGS_HIGH_RESET;
            low_q <= SLOT_FLAGS_LOW_RESET;
            status_q <= IRQ_RESET;
            mask_q <= IRQ_RESET;
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            irq_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            fmt_q <= fmt_d;
            high_q <= high_d;
            low_q <= low_d;
            status_q <= status_d;
            mask_q <= mask_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            irq_q <= irq_d;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq = irq_q;

    // ==========================================================
    // Slot timing and tag stream
    logic [5:0] bit_q, bit_d, slotLen, dataBits;
    logic [3:0] slot_q, slot_d;
    logic fs_q, fs_d, tx_q, tx_d, den_q, den_d;
    logic [15:0] tagWord;
    logic frameStart;

    always_comb begin
        // Slot 0 tag: frame valid, command slot bits held low, audio slots 3..12
        tagWord = {high_q[FRAME_VALID_BIT], 2'h0, high_q[4:0],
                   low_q[7:3], 3'h0};
        dataBits = codeToCount(fmt_q[DATA_BITS_LSB +: 3]);
        if (isAc97) begin
            slotLen = (slot_q == 4'h0) ? AC_TAG_SLOT_CYCLES
                                       : AC_AUDIO_SLOT_CYCLES;
        end else begin
            slotLen = codeToCount(fmt_q[SLOT_LEN_LSB +: 3]);
        end
        bit_d = bit_q;
        slot_d = slot_q;
        fs_d = fs_q;
        tx_d = tx_q;
        den_d = den_q;
        frameStart = 1'b0;
        if (!isAc97 && !isMode5) begin
            bit_d = 6'h0;
            slot_d = 4'h0;
            fs_d = 1'b0;
            tx_d = 1'b0;
            den_d = 1'b0;
        end else if (sclkRise) begin
            if (bit_q == slotLen - 6'h1) begin
                bit_d = 6'h0;
                if (slot_q == 4'(NUM_SLOTS - 1)) begin
                    slot_d = 4'h0;
                    frameStart = 1'b1;
                end else begin
                    slot_d = slot_q + 4'h1;
                end
            end else begin
                bit_d = bit_q + 6'h1;
            end
            fs_d = (slot_d == 4'h0);
            tx_d = isAc97 && (slot_d == 4'h0) &&
                   tagWord[4'hf - bit_d[3:0]];
            // Command slots carry full-width words
            den_d = isMode5 && ((slot_d == CMD_ADDR_SLOT) ||
                    (slot_d == CMD_DATA_SLOT) || (bit_d < dataBits));
        end
    end

    always_comb begin
        priRdy_d = priRdy_q;
        secRdy_d = secRdy_q;
        if (isAc97 && sclkFall && slot_q == 4'h0 && bit_q == 6'h0) begin
            priRdy_d = priPipe_q[1];
            secRdy_d = secPipe_q[1];
        end
        events = 3'h0;
        events[IRQ_FRAME_BIT] = frameStart;
        events[IRQ_PRI_BIT] = priRdy_d ^ priRdy_q;
        events[IRQ_SEC_BIT] = secRdy_d ^ secRdy_q;
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            bit_q <= 6'h0;
            slot_q <= 4'h0;
            fs_q <= 1'b0;
            tx_q <= 1'b0;
            den_q <= 1'b0;
            priRdy_q <= 1'b0;
            secRdy_q <= 1'b0;
        end else begin
            bit_q <= bit_d;
            slot_q <= slot_d;
            fs_q <= fs_d;
            tx_q <= tx_d;
            den_q <= den_d;
            priRdy_q <= priRdy_d;
            secRdy_q <= secRdy_d;
        end
    end
    assign frameSync = fs_q;
    assign txData = tx_q;
    assign slotIndex = slot_q;
    assign bitIndex = bit_q;
    assign audioDataEn = den_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_n);

    ack_single_a: assert property (ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (req |=> ack_q)
        else $error("request not answered next cycle");
    ready_gated_a: assert property (!isAc97 |=> $stable(priRdy_q) &&
        $stable(secRdy_q))
        else $error("ready flag moved outside AC97 mode");
    pri_ready_a: assert property (isAc97 && sclkFall && slot_q == 4'h0 &&
        bit_q == 6'h0 |=> priRdy_q == $past(priPipe_q[1]))
        else $error("primary ready not taken from bit 15");
    sec_ready_a: assert property (isAc97 && sclkFall && slot_q == 4'h0 &&
        bit_q == 6'h0 |=> secRdy_q == $past(secPipe_q[1]))
        else $error("secondary ready not taken from tag");
    frame_valid_a: assert property (isAc97 && sclkRise &&
        slot_d == 4'h0 && bit_d == 6'h0 |=> tx_q == $past(high_q[7]))
        else $error("frame valid not sent first");
    slot_high_a: assert property (isAc97 && sclkRise &&
        slot_d == 4'h0 && bit_d == 6'h3 |=> tx_q == $past(high_q[4]))
        else $error("slot 3 tag wrong");
    slot_low_a: assert property (isAc97 && sclkRise &&
        slot_d == 4'h0 && bit_d == 6'h8 |=> tx_q == $past(low_q[7]))
        else $error("slot 8 tag wrong");
    mode5_only_a: assert property (sclkRise && !isMode5 |=> !den_q)
        else $error("data window outside mode 5");
    width_limit_a: assert property (sclkRise && isMode5 && slot_d > 4'h2 &&
        bit_d >= dataBits |=> !den_q)
        else $error("data window exceeds data bits");
    cmd_slot_a: assert property (sclkRise && isMode5 &&
        slot_d == CMD_ADDR_SLOT |=> den_q)
        else $error("command slot width clipped");
    slot_wrap_a: assert property (sclkRise && isMode5 &&
        bit_q == slotLen - 6'h1 |=> bit_q == 6'h0)
        else $error("slot length not honoured");
    irq_level_a: assert property (##1 irq_q == $past(|(status_q & mask_q)))
        else $error("interrupt level wrong");

    frame_start_c: cover property (isAc97 && frameStart);
    pri_ready_c: cover property (isAc97 && !priRdy_q ##1 priRdy_q);
    mode5_data_c: cover property (isMode5 && den_q);
    bus_write_c: cover property (wrLane0 && idx == IDX_SLOT_FLAGS_HIGH);
endmodule
`default_nettype wire

// ### include/codec_frame_slot_pkg.sv
// Constants for the codec frame and time-slot configuration block.
// Assumes a Wishbone slave with 32-bit data and word-indexed registers.
package codec_frame_slot_pkg;
    // ==========================================================
    // Register indices (byte address = 4 * index)
    localparam logic [15:0] IDX_MODE = 16'h0000;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h0001;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h0002;
    localparam logic [15:0] IDX_RX_SLOT_FORMAT = 16'hffd6;
    localparam logic [15:0] IDX_SLOT_FLAGS_HIGH = 16'hffd7;
    localparam logic [15:0] IDX_SLOT_FLAGS_LOW = 16'hffd8;
    // ==========================================================
    // Reset values
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] RX_SLOT_FORMAT_RESET = 8'h00;
    localparam logic [7:0] SLOT_FLAGS_HIGH_RESET = 8'h00;
    localparam logic [7:0] SLOT_FLAGS_LOW_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // ==========================================================
    // Field positions
    localparam int FRAME_VALID_BIT = 7;
    localparam int PRI_READY_BIT = 6;
    localparam int SEC_READY_BIT = 5;
    localparam int DATA_BITS_LSB = 3;
    localparam int SLOT_LEN_LSB = 0;
    localparam int PRI_READY_IN_BIT = 15;
    localparam int IRQ_FRAME_BIT = 0;
    localparam int IRQ_PRI_BIT = 1;
    localparam int IRQ_SEC_BIT = 2;
    // ==========================================================
    // Frame timing: slot lengths in serial-clock cycles, command slot numbers
    localparam logic [5:0] AC_TAG_SLOT_CYCLES = 6'h10;
    localparam logic [5:0] AC_AUDIO_SLOT_CYCLES = 6'h14;
    localparam logic [3:0] CMD_ADDR_SLOT = 4'h1;
    localparam logic [3:0] CMD_DATA_SLOT = 4'h2;
    // ==========================================================
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_AC97 = 2'h1,
        MODE_I2S5 = 2'h2
    } port_mode_t;
endpackage

// ### dv/codec_partner.sv
// Behavioural model of the primary and secondary codecs.
// Assumes slotIndex from the block marks where the frame stands.
`timescale 1ns/1ps
`default_nettype none
module codec_partner (
    input wire logic run, // Serial clock runs while high
    input wire logic rdyPri, // Primary codec ready
    input wire logic rdySec, // Secondary codec ready
    input wire logic [3:0] slotIndex, // Slot seen by the block
    output logic sclk, // Serial clock, 64 ns period
    output logic priData, // Primary serial data
    output logic secData // Secondary serial data
);
    initial begin
        sclk = 1'b0;
        priData = 1'b0;
        secData = 1'b0;
    end
    // A stopped clock rests low
    always #32 sclk = (run || sclk) ? ~sclk : 1'b0;
    // Ready bit leads slot 0; elsewhere the lines keep toggling
    always @(posedge sclk) begin
        if (slotIndex == 4'hc || slotIndex == 4'h0) begin
            priData <= rdyPri;
            secData <= rdySec;
        end else begin
            priData <= ~priData;
            secData <= ~secData;
        end
    end
endmodule
`default_nettype wire

// ### dv/codec_frame_slot_config_tb.sv
// Self-checking bench for the frame and slot configuration block.
// Assumes the codec partner model drives the serial side.
`timescale 1ns/1ps
`default_nettype none
module codec_frame_slot_config_tb
    import codec_frame_slot_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic run = 1'b0, rdyPri = 1'b0, rdySec = 1'b0;
    logic [17:0] adr = 18'h0;
    logic [31:0] wdat = 32'h0, rdat, tag, dout;
    logic ack, irq, sclk, priD, secD, fsync, txd, den;
    logic [3:0] slot;
    logic [5:0] bitIdx;
    int fails = 0, totalChecks = 0, len, en, fs, lastBit;
    int lenTab [8] = '{8, 16, 18, 20, 24, 32, 32, 32};

    initial begin
        forever #2.5 clk = ~clk;
    end

    codec_frame_slot_config i_dut (.clk(clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
        .irq(irq), .codecSerialClock(sclk), .priDataIn(priD),
        .secDataIn(secD), .frameSync(fsync), .txData(txd),
        .slotIndex(slot), .bitIndex(bitIdx), .audioDataEn(den));

    codec_partner i_partner (.run(run), .rdyPri(rdyPri), .rdySec(rdySec),
        .slotIndex(slot), .sclk(sclk), .priData(priD), .secData(secD));

    // ==========================================================
    // Tasks
    task automatic finalReport;
        $display("checks=%0d mismatches=%0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [15:0] idx,
                        input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= {24'h0, d};
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rdat, exp);
    endtask

    // Measures one whole occurrence of slot s at serial clock falls
    task automatic watch(input logic [3:0] s);
        len = 0;
        en = 0;
        fs = 0;
        lastBit = 0;
        tag = 32'h0;
        @(negedge sclk);
        while (slot === s) @(negedge sclk);
        while (slot !== s) @(negedge sclk);
        while (slot === s) begin
            len++;
            en += int'(den);
            fs += int'(fsync);
            lastBit = int'(bitIdx);
            tag = {tag[30:0], txd};
            @(negedge sclk);
        end
    endtask

    // ==========================================================
    // Tests
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(IDX_RX_SLOT_FORMAT, {24'h0, RX_SLOT_FORMAT_RESET});
        rdc(IDX_SLOT_FLAGS_HIGH, {24'h0, SLOT_FLAGS_HIGH_RESET});
        rdc(IDX_SLOT_FLAGS_LOW, {24'h0, SLOT_FLAGS_LOW_RESET});
        wr(IDX_RX_SLOT_FORMAT, 8'hff);
        rdc(IDX_RX_SLOT_FORMAT, 32'h3f);
        wr(IDX_SLOT_FLAGS_HIGH, 8'hff);
        rdc(IDX_SLOT_FLAGS_HIGH, 32'h9f);
        wr(IDX_SLOT_FLAGS_LOW, 8'hff);
        rdc(IDX_SLOT_FLAGS_LOW, 32'hf8);
        wr(16'h0100, 8'h5a);
        rdc(16'h0100, 32'h0);
        // AC97 frame: tags, ready flags, interrupt
        wr(IDX_RX_SLOT_FORMAT, 8'h01);
        wr(IDX_SLOT_FLAGS_HIGH, 8'h94);
        wr(IDX_SLOT_FLAGS_LOW, 8'h50);
        wr(IDX_IRQ_MASK, 8'h01);
        rdyPri <= 1'b1;
        rdySec <= 1'b1;
        run <= 1'b1;
        wr(IDX_MODE, {6'h0, MODE_AC97});
        watch(4'h0);
        chk(len, 32'd16);
        chk(fs, 32'd16);
        chk(lastBit, 32'd15);
        chk(tag, {16'h0, 1'b1, 2'h0, 5'h14, 5'h0a, 3'h0});
        watch(4'h3);
        chk(len, 32'd20);
        chk(fs, 32'd0);
        chk(lastBit, 32'd19);
        rdc(IDX_SLOT_FLAGS_HIGH, 32'hf4);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdc(IDX_IRQ_STATUS, 32'h7);
        wr(IDX_IRQ_STATUS, 8'h07);
        rdc(IDX_IRQ_STATUS, 32'h0);
        // Empty frame: software drops frame valid and every slot flag
        wr(IDX_SLOT_FLAGS_HIGH, 8'h00);
        wr(IDX_SLOT_FLAGS_LOW, 8'h00);
        rdc(IDX_SLOT_FLAGS_HIGH, 32'h60);
        watch(4'h0);
        chk(tag, 32'h0);
        chk(len, 32'd16);
        // Mode 5 with every width and length code
        for (int c = 0; c < 8; c++) begin
            wr(IDX_MODE, 8'h00);
            wr(IDX_RX_SLOT_FORMAT, {2'h0, c[2:0], c[2:0]});
            wr(IDX_MODE, {6'h0, MODE_I2S5});
            watch(4'h3);
            chk(len, lenTab[c]);
            chk(en, lenTab[c]);
            chk(lastBit, lenTab[c] - 1);
            chk(tag, 32'h0);
        end
        // Narrow data in long slots; command slot stays full
        wr(IDX_MODE, 8'h00);
        wr(IDX_RX_SLOT_FORMAT, 8'h05);
        wr(IDX_MODE, {6'h0, MODE_I2S5});
        watch(4'h1);
        chk(en, 32'd32);
        watch(4'h3);
        chk(en, 32'd8);
        finalReport;
    end

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        finalReport;
    end
endmodule
`default_nettype wire
